// file: common/mac_cfg_pkg.sv
// constants, register layout and state types for the mac configuration block
package mac_cfg_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  CONF_OFS        = 8'h00;
	localparam logic [7:0]  STAT_OFS        = 8'h04;
	localparam logic [31:0] CONF_RESET      = 32'h0000_0000;
	localparam int          SPEED_BIT       = 14;
	localparam int          DRO_BIT         = 13;
	localparam int          LOOP_BIT        = 12;
	localparam int          DUPLEX_BIT      = 11;
	localparam int          CSUM_BIT        = 10;
	localparam int          RETRY_DIS_BIT   = 9;
	localparam int          LINK_BIT        = 8;
	localparam int          STRIP_BIT       = 7;
	localparam int          BL_HI_BIT       = 6;
	localparam int          BL_LO_BIT       = 5;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 100;
	localparam int BIT_NS_10M      = 100;
	localparam int BIT_NS_100M     = 10;
	localparam int BIT_NS_1000M    = 1;
	localparam int SLOT_BITS_MII   = 512;
	localparam int SLOT_BITS_GMII  = 4096;
	localparam int SLOT_CYC_10M    = (SLOT_BITS_MII * BIT_NS_10M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOT_CYC_100M   = (SLOT_BITS_MII * BIT_NS_100M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOT_CYC_1000M  = (SLOT_BITS_GMII * BIT_NS_1000M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam logic [7:0]  PRE_BYTE       = 8'h55;
	localparam logic [7:0]  SFD_BYTE       = 8'hd5;
	localparam logic [3:0]  PRE_LEN        = 4'h7;
	localparam logic [15:0] ETH_HDR_LEN    = 16'h000e;
	localparam logic [15:0] VLAN_HDR_LEN   = 16'h0012;
	localparam logic [15:0] VLAN_TPID      = 16'h8100;
	localparam logic [15:0] IPV4_TYPE      = 16'h0800;
	localparam logic [15:0] MAX_STRIP_LEN  = 16'h05dc;
	localparam logic [15:0] CSUM_GOOD      = 16'hffff;

	// ----------------------------------------------------------------
	// back-off exponent caps per limit select, and the back-off lfsr seed
	// ----------------------------------------------------------------
	localparam logic [4:0] BL_CAP_0 = 5'h0a;
	localparam logic [4:0] BL_CAP_1 = 5'h08;
	localparam logic [4:0] BL_CAP_2 = 5'h04;
	localparam logic [4:0] BL_CAP_3 = 5'h01;
	localparam logic [15:0] LFSR_SEED = 16'hace1;

	typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_BACKOFF} tx_state_t;

endpackage : mac_cfg_pkg

// file: hw/mac_cfg_core.sv
// ethernet mac configuration bits with mii transmit/receive datapath
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module mac_cfg_core #(
	parameter bit       FULL_DUPLEX_ONLY = 1'b0,
	parameter bit       CSUM_TYPE2       = 1'b0,
	parameter int       MAX_ATTEMPTS     = 16
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// register bus
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// phy pins
	input  wire logic        mii_tx_clk,
	input  wire logic        mii_rx_clk,
	input  wire logic        mii_rx_dv,
	input  wire logic [3:0]  mii_rxd,
	input  wire logic        mii_col,
	input  wire logic        gmii_mode,
	output logic             mii_tx_en,
	output logic      [3:0]  mii_txd,
	output logic             link_state_report,
	output logic             fast_speed_select,
	// transmit stream
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	input  wire logic        tx_last,
	output logic             tx_ready,
	output logic             tx_rewind,
	output logic             tx_done,
	output logic      [6:0]  tx_status,
	// receive stream
	output logic      [7:0]  rx_data,
	output logic             rx_valid,
	output logic             rx_end,
	output logic      [31:0] rx_status
);

	// ----------------------------------------------------------------
	// one's complement add with end-around carry
	// ----------------------------------------------------------------
	function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction : oc_add

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [8:0]  pin_meta_ff;
	logic [8:0]  pin_sync_ff;
	logic        tx_clk_prev_ff;
	logic        rx_clk_prev_ff;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_meta_ff    <= '0;
			pin_sync_ff    <= '0;
			tx_clk_prev_ff <= 1'b0;
			rx_clk_prev_ff <= 1'b0;
		end else begin
			pin_meta_ff    <= {gmii_mode, mii_col, mii_rxd, mii_rx_dv, mii_rx_clk, mii_tx_clk};
			pin_sync_ff    <= pin_meta_ff;
			tx_clk_prev_ff <= pin_sync_ff[0];
			rx_clk_prev_ff <= pin_sync_ff[1];
		end
	end

	wire       tx_edge   = pin_sync_ff[0] & ~tx_clk_prev_ff;
	wire       rx_edge   = pin_sync_ff[1] & ~rx_clk_prev_ff;
	wire       s_rx_dv   = pin_sync_ff[2];
	wire [3:0] s_rxd     = pin_sync_ff[6:3];
	wire       s_col     = pin_sync_ff[7];
	wire       s_gmii    = pin_sync_ff[8];

	// ----------------------------------------------------------------
	// configuration register
	// ----------------------------------------------------------------
	logic [14:5] conf_ff;
	logic        ack_ff;
	logic [31:0] rdata_ff;

	wire        cfg_speed   = conf_ff[mac_cfg_pkg::SPEED_BIT];
	wire        cfg_dro     = conf_ff[mac_cfg_pkg::DRO_BIT];
	wire        cfg_loop    = conf_ff[mac_cfg_pkg::LOOP_BIT];
	wire        cfg_duplex  = FULL_DUPLEX_ONLY | conf_ff[mac_cfg_pkg::DUPLEX_BIT];
	wire        cfg_csum    = conf_ff[mac_cfg_pkg::CSUM_BIT];
	wire        cfg_retry_d = conf_ff[mac_cfg_pkg::RETRY_DIS_BIT];
	wire        cfg_strip   = conf_ff[mac_cfg_pkg::STRIP_BIT];
	wire [1:0]  cfg_bl      = FULL_DUPLEX_ONLY ? 2'h0 : conf_ff[mac_cfg_pkg::BL_HI_BIT:mac_cfg_pkg::BL_LO_BIT];

	wire        bus_req     = avs_read | avs_write;
	wire        hit_conf    = avs_address == mac_cfg_pkg::CONF_OFS;
	wire        hit_stat    = avs_address == mac_cfg_pkg::STAT_OFS;
	wire        do_write    = avs_write & ack_ff & hit_conf;

	logic [31:0] conf_view;
	logic [31:0] stat_view;
	logic [14:5] nxt_conf;

	always_comb begin
		conf_view = '0;
		conf_view[14:5] = conf_ff;
		conf_view[mac_cfg_pkg::DUPLEX_BIT] = cfg_duplex;
		conf_view[mac_cfg_pkg::BL_HI_BIT:mac_cfg_pkg::BL_LO_BIT] = cfg_bl;
		nxt_conf = conf_ff;
		if (avs_byteenable[1]) begin
			nxt_conf[14:8] = avs_writedata[14:8];
		end
		if (avs_byteenable[0]) begin
			nxt_conf[7:5] = avs_writedata[7:5];
		end
	end

	assign avs_waitrequest = bus_req & ~ack_ff;
	assign avs_readdata    = rdata_ff;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			conf_ff  <= mac_cfg_pkg::CONF_RESET[14:5];
			ack_ff   <= 1'b0;
			rdata_ff <= '0;
		end else begin
			ack_ff <= bus_req & ~ack_ff;
			if (bus_req & ~ack_ff) begin
				rdata_ff <= hit_conf ? conf_view : (hit_stat ? stat_view : 32'h0000_0000);
			end
			if (do_write) begin
				conf_ff <= nxt_conf;
			end
		end
	end

	assign link_state_report = conf_ff[mac_cfg_pkg::LINK_BIT];
	assign fast_speed_select = cfg_speed;

	// ----------------------------------------------------------------
	// back-off slot length and random source
	// ----------------------------------------------------------------
	logic [15:0] lfsr_ff;
	wire  [9:0]  slot_cyc = s_gmii ? 10'(mac_cfg_pkg::SLOT_CYC_1000M)
		: (cfg_speed ? 10'(mac_cfg_pkg::SLOT_CYC_100M) : 10'(mac_cfg_pkg::SLOT_CYC_10M));

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lfsr_ff <= mac_cfg_pkg::LFSR_SEED;
		end else begin
			lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
		end
	end

	// ----------------------------------------------------------------
	// transmit
	// ----------------------------------------------------------------
	mac_cfg_pkg::tx_state_t tx_state_ff;
	logic [3:0] pre_cnt_ff;
	logic       tx_nib_ff;
	logic [7:0] cur_byte_ff;
	logic       cur_last_ff;
	logic       txen_ff;
	logic [3:0] txd_ff;
	logic [4:0] attempt_ff;
	logic [9:0] bo_r_ff;
	logic [9:0] bo_slot_ff;
	logic       tx_done_ff;
	logic       tx_rewind_ff;
	logic [6:0] tx_status_ff;

	wire        in_pre    = tx_state_ff == mac_cfg_pkg::TX_PRE;
	wire        in_data   = tx_state_ff == mac_cfg_pkg::TX_DATA;
	wire        pre_fin   = in_pre & tx_edge & tx_nib_ff & (pre_cnt_ff == mac_cfg_pkg::PRE_LEN);
	wire        data_next = in_data & tx_edge & tx_nib_ff & ~cur_last_ff;
	wire        collided  = s_col & ~cfg_duplex & ~cfg_loop & (in_pre | in_data);
	wire [4:0]  next_n    = attempt_ff + 5'h01;
	wire        give_up   = cfg_retry_d | (next_n >= 5'(MAX_ATTEMPTS));
	wire [7:0]  pre_byte  = (pre_cnt_ff == mac_cfg_pkg::PRE_LEN) ? mac_cfg_pkg::SFD_BYTE : mac_cfg_pkg::PRE_BYTE;
	wire [7:0]  send_byte = in_pre ? pre_byte : cur_byte_ff;
	wire [3:0]  send_nib  = tx_nib_ff ? send_byte[7:4] : send_byte[3:0];

	logic [4:0] bl_cap;
	logic [4:0] bo_k;
	always_comb begin
		unique case (cfg_bl)
			2'h0: bl_cap = mac_cfg_pkg::BL_CAP_0;
			2'h1: bl_cap = mac_cfg_pkg::BL_CAP_1;
			2'h2: bl_cap = mac_cfg_pkg::BL_CAP_2;
			2'h3: bl_cap = mac_cfg_pkg::BL_CAP_3;
		endcase
		bo_k = (next_n < bl_cap) ? next_n : bl_cap;
	end
	wire [10:0] bo_span = (11'h001 << bo_k) - 11'h001;
	wire [9:0]  bo_r    = lfsr_ff[9:0] & bo_span[9:0];

	assign tx_ready  = pre_fin | data_next;
	assign mii_tx_en = txen_ff;
	assign mii_txd   = txd_ff;
	assign tx_done   = tx_done_ff;
	assign tx_rewind = tx_rewind_ff;
	assign tx_status = tx_status_ff;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_state_ff  <= mac_cfg_pkg::TX_IDLE;
			pre_cnt_ff   <= '0;
			tx_nib_ff    <= 1'b0;
			cur_byte_ff  <= '0;
			cur_last_ff  <= 1'b0;
			txen_ff      <= 1'b0;
			txd_ff       <= '0;
			attempt_ff   <= '0;
			bo_r_ff      <= '0;
			bo_slot_ff   <= '0;
			tx_done_ff   <= 1'b0;
			tx_rewind_ff <= 1'b0;
			tx_status_ff <= '0;
		end else begin
			tx_done_ff   <= 1'b0;
			tx_rewind_ff <= 1'b0;
			unique case (tx_state_ff)
				mac_cfg_pkg::TX_IDLE: begin
					if (tx_edge) begin
						txen_ff   <= 1'b0;
						txd_ff    <= '0;
						tx_nib_ff <= 1'b0;
						pre_cnt_ff <= '0;
						if (tx_valid) begin
							tx_state_ff <= mac_cfg_pkg::TX_PRE;
						end
					end
				end
				mac_cfg_pkg::TX_PRE, mac_cfg_pkg::TX_DATA: begin
					if (collided) begin
						txen_ff      <= 1'b0;
						txd_ff       <= '0;
						tx_rewind_ff <= 1'b1;
						if (give_up) begin
							tx_done_ff   <= 1'b1;
							tx_status_ff <= {next_n, 2'b11};
							attempt_ff   <= '0;
							tx_state_ff  <= mac_cfg_pkg::TX_IDLE;
						end else begin
							attempt_ff  <= next_n;
							bo_r_ff     <= bo_r;
							bo_slot_ff  <= slot_cyc;
							tx_state_ff <= mac_cfg_pkg::TX_BACKOFF;
						end
					end else if (tx_edge) begin
						txen_ff   <= 1'b1;
						txd_ff    <= send_nib;
						tx_nib_ff <= ~tx_nib_ff;
						if (in_pre & tx_nib_ff) begin
							pre_cnt_ff <= pre_cnt_ff + 4'h1;
						end
						if (tx_ready) begin
							cur_byte_ff <= tx_data;
							cur_last_ff <= tx_last;
							tx_state_ff <= mac_cfg_pkg::TX_DATA;
						end
						if (tx_ready & ~tx_valid) begin
							tx_done_ff   <= 1'b1;
							tx_status_ff <= {next_n, 2'b01};
							attempt_ff   <= '0;
							tx_state_ff  <= mac_cfg_pkg::TX_IDLE;
						end else if (in_data & tx_nib_ff & cur_last_ff) begin
							tx_done_ff   <= 1'b1;
							tx_status_ff <= {next_n, 2'b00};
							attempt_ff   <= '0;
							tx_state_ff  <= mac_cfg_pkg::TX_IDLE;
						end
					end
				end
				mac_cfg_pkg::TX_BACKOFF: begin
					// waits r slots; r of zero retries at once
					if (bo_r_ff == 10'h000) begin
						tx_state_ff <= mac_cfg_pkg::TX_IDLE;
					end else if (bo_slot_ff <= 10'h001) begin
						bo_r_ff    <= bo_r_ff - 10'h001;
						bo_slot_ff <= slot_cyc;
					end else begin
						bo_slot_ff <= bo_slot_ff - 10'h001;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receive
	// ----------------------------------------------------------------
	wire        rx_dv_src = cfg_loop ? txen_ff : s_rx_dv;
	wire [3:0]  rxd_src   = cfg_loop ? txd_ff : s_rxd;
	// loopback still steps on the receive clock edges; tx clock is not routed here
	wire        rx_block  = cfg_dro & ~cfg_duplex & txen_ff;

	logic        rx_phase_ff;
	logic [3:0]  rx_lo_ff;
	logic        rx_active_ff;
	logic        rx_drop_ff;
	logic [15:0] rx_idx_ff;
	logic [15:0] eth_type_ff;
	logic        vlan_ff;
	logic [15:0] ip_hlen_ff;
	logic [15:0] ip_tot_ff;
	logic [15:0] hdr_sum_ff;
	logic [15:0] pay_sum_ff;
	logic [7:0]  rx_data_ff;
	logic        rx_valid_ff;
	logic        rx_end_ff;
	logic [31:0] rx_status_ff;

	wire        byte_stb  = rx_edge & rx_dv_src & rx_phase_ff;
	wire [7:0]  rx_byte   = {rxd_src, rx_lo_ff};
	wire [15:0] hdr_end   = vlan_ff ? mac_cfg_pkg::VLAN_HDR_LEN : mac_cfg_pkg::ETH_HDR_LEN;
	wire [15:0] ip_off    = rx_idx_ff - hdr_end;
	wire        in_ip     = rx_idx_ff >= hdr_end;
	wire        is_ipv4   = eth_type_ff == mac_cfg_pkg::IPV4_TYPE;
	wire        in_hdr    = in_ip & ((ip_off == 16'h0000) | (ip_off < ip_hlen_ff));
	wire        in_pay    = in_ip & ~in_hdr & (ip_off < ip_tot_ff);
	wire [15:0] csum_word = ip_off[0] ? {8'h00, rx_byte} : {rx_byte, 8'h00};
	wire        len_small = eth_type_ff <= mac_cfg_pkg::MAX_STRIP_LEN;
	wire        keep_byte = ~cfg_strip | ~len_small | (rx_idx_ff < 16'h000e)
		| (rx_idx_ff < hdr_end + eth_type_ff);
	wire        frame_end = rx_edge & ~rx_dv_src & rx_active_ff;
	wire        hdr_err   = cfg_csum & is_ipv4 & (hdr_sum_ff != mac_cfg_pkg::CSUM_GOOD);
	wire        pay_err   = CSUM_TYPE2 & cfg_csum & is_ipv4 & (pay_sum_ff != mac_cfg_pkg::CSUM_GOOD);
	wire [15:0] pay_csum  = (~CSUM_TYPE2 & cfg_csum) ? ~pay_sum_ff : 16'h0000;

	assign rx_data   = rx_data_ff;
	assign rx_valid  = rx_valid_ff;
	assign rx_end    = rx_end_ff;
	assign rx_status = rx_status_ff;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_phase_ff  <= 1'b0;
			rx_lo_ff     <= '0;
			rx_active_ff <= 1'b0;
			rx_drop_ff   <= 1'b0;
			rx_idx_ff    <= '0;
			eth_type_ff  <= '0;
			vlan_ff      <= 1'b0;
			ip_hlen_ff   <= '0;
			ip_tot_ff    <= '0;
			hdr_sum_ff   <= '0;
			pay_sum_ff   <= '0;
			rx_data_ff   <= '0;
			rx_valid_ff  <= 1'b0;
			rx_end_ff    <= 1'b0;
			rx_status_ff <= '0;
		end else begin
			rx_valid_ff <= 1'b0;
			rx_end_ff   <= 1'b0;
			if (rx_edge & ~rx_dv_src) begin
				rx_phase_ff  <= 1'b0;
				rx_active_ff <= 1'b0;
				rx_drop_ff   <= 1'b0;
				if (frame_end & ~rx_drop_ff) begin
					rx_end_ff    <= 1'b1;
					rx_status_ff <= {12'h000, cfg_strip & len_small, vlan_ff, pay_err, hdr_err, pay_csum};
				end
			end else if (rx_edge) begin
				rx_phase_ff <= ~rx_phase_ff;
				rx_lo_ff    <= rxd_src;
			end
			if (byte_stb & ~rx_active_ff & ~rx_block & (rx_byte == mac_cfg_pkg::SFD_BYTE)) begin
				rx_active_ff <= 1'b1;
				rx_idx_ff    <= '0;
				eth_type_ff  <= '0;
				vlan_ff      <= 1'b0;
				ip_hlen_ff   <= '0;
				ip_tot_ff    <= '0;
				hdr_sum_ff   <= '0;
				pay_sum_ff   <= '0;
			end else if (byte_stb & rx_active_ff) begin
				rx_idx_ff <= (rx_idx_ff == 16'hffff) ? rx_idx_ff : rx_idx_ff + 16'h0001;
				if (rx_block) begin
					rx_drop_ff <= 1'b1;
				end
				if ((rx_idx_ff == 16'h000c) | (rx_idx_ff == 16'h0010 & vlan_ff)) begin
					eth_type_ff[15:8] <= rx_byte;
				end
				if ((rx_idx_ff == 16'h000d) | (rx_idx_ff == 16'h0011 & vlan_ff)) begin
					eth_type_ff[7:0] <= rx_byte;
				end
				if (rx_idx_ff == 16'h000d) begin
					vlan_ff <= {eth_type_ff[15:8], rx_byte} == mac_cfg_pkg::VLAN_TPID;
				end
				if (in_ip & (ip_off == 16'h0000)) begin
					ip_hlen_ff <= {10'h000, rx_byte[3:0], 2'b00};
				end
				if (in_ip & (ip_off == 16'h0002)) begin
					ip_tot_ff[15:8] <= rx_byte;
				end
				if (in_ip & (ip_off == 16'h0003)) begin
					ip_tot_ff[7:0] <= rx_byte;
				end
				if (in_hdr) begin
					hdr_sum_ff <= oc_add(hdr_sum_ff, csum_word);
				end
				if (in_pay) begin
					pay_sum_ff <= oc_add(pay_sum_ff, csum_word);
				end
				if (keep_byte & ~rx_block & ~rx_drop_ff) begin
					rx_data_ff  <= rx_byte;
					rx_valid_ff <= 1'b1;
				end
			end
		end
	end

	assign stat_view = {15'h0000, rx_status_ff[17:16], tx_status_ff, rx_drop_ff, rx_active_ff,
		attempt_ff, tx_state_ff != mac_cfg_pkg::TX_IDLE};

endmodule : mac_cfg_core

// file: tb/phy_model.sv
// phy model: free running link clocks, echo of own transmit, collision on demand
`timescale 1ns/1ps
module phy_model (
	// link clocks
	output logic       tx_clk,
	output logic       rx_clk,
	// receive pins
	output logic       rx_dv,
	output logic [3:0] rxd,
	output logic       col,
	// transmit pin and bench control
	input  wire logic  tx_en,
	input  wire logic [3:0] txd,
	input  wire logic  col_req
);
	// ------------------------------------------------------------
	// clocks and lines
	// ------------------------------------------------------------
	initial begin
		tx_clk = 1'b0;
		forever #400 tx_clk = ~tx_clk;
	end
	// rx clock keeps running in loopback, the mac does not feed it back
	initial begin
		rx_clk = 1'b0;
		#137;
		forever #400 rx_clk = ~rx_clk;
	end
	logic [3:0] idle_d = 4'h5;
	// idle data wanders so a stale nibble never looks valid
	always @(posedge rx_clk) idle_d <= ~idle_d;
	// shared medium: own transmission comes back on the receive pins
	assign rx_dv = tx_en;
	assign rxd   = tx_en ? txd : idle_d;
	assign col   = col_req & tx_en;
endmodule : phy_model

// file: tb/mac_cfg_monitor.sv
// concurrent checks on the mac configuration block ports
`timescale 1ns/1ps
module mac_cfg_monitor #(
	parameter int MAX_ATTEMPTS = 16
) (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// register bus
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// phy side
	input wire logic        mii_tx_en,
	input wire logic        link_state_report,
	input wire logic        fast_speed_select,
	// streams
	input wire logic        tx_rewind,
	input wire logic        tx_done,
	input wire logic [6:0]  tx_status,
	input wire logic        rx_valid,
	input wire logic        rx_end,
	input wire logic [31:0] rx_status
);
	// ------------------------------------------------------------
	// config shadow
	// ------------------------------------------------------------
	logic [31:0] cfg_ff;
	logic [31:0] nxt_cfg;
	logic [4:0]  rw_cnt_ff;
	wire         wr_hit = avs_write & ~avs_waitrequest & (avs_address == mac_cfg_pkg::CONF_OFS);
	wire         half   = ~cfg_ff[11] & ~cfg_ff[12];
	assign nxt_cfg = {17'h0, avs_byteenable[1] ? avs_writedata[14:8] : cfg_ff[14:8],
		avs_byteenable[0] ? avs_writedata[7:5] : cfg_ff[7:5], 5'h0};
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) cfg_ff <= mac_cfg_pkg::CONF_RESET;
		else if (wr_hit) cfg_ff <= nxt_cfg;
	end
	// collisions since the last finished frame
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) rw_cnt_ff <= 5'h00;
		else if (tx_done) rw_cnt_ff <= 5'h00;
		else if (tx_rewind) rw_cnt_ff <= rw_cnt_ff + 5'h01;
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_BUS_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("register bus wait longer than one cycle");
	AST_SPEED_PIN: assert property (fast_speed_select == cfg_ff[14])
		else $error("speed select pin differs from config");
	AST_LINK_PIN: assert property (link_state_report == cfg_ff[8])
		else $error("link state pin differs from config");
	AST_CONF_READ: assert property (avs_read && !avs_waitrequest && avs_address == 8'h00 |-> avs_readdata == cfg_ff)
		else $error("config read back wrong");
	AST_OWN_RX: assert property (cfg_ff[13] && half && mii_tx_en |-> !rx_valid)
		else $error("own frame received in half duplex");
	AST_FD_NO_COL: assert property (cfg_ff[11] |-> !tx_rewind)
		else $error("collision handled in full duplex");
	AST_ABORT: assert property (tx_rewind && cfg_ff[9] && half |-> ##[0:20] (tx_done && tx_status[1:0] == 2'b11))
		else $error("single attempt not aborted");
	AST_RETRY: assert property ($rose(tx_rewind) && !cfg_ff[9] && half && cfg_ff[6:5] == 2'b11 && cfg_ff[14] &&
		rw_cnt_ff < MAX_ATTEMPTS - 1 |-> ##2 !mii_tx_en ##[1:90] mii_tx_en)
		else $error("retry missing or backoff too long");
	AST_NO_CSUM: assert property (rx_end && !cfg_ff[10] |-> rx_status[17:0] == 18'h00000)
		else $error("checksum status set with offload off");
	AST_NO_STRIP: assert property (rx_end && !cfg_ff[7] |-> !rx_status[19])
		else $error("strip flagged with strip off");
	cover property (rx_end && cfg_ff[12]);
	cover property (tx_done && tx_status[1:0] == 2'b11);
	cover property (tx_rewind && !cfg_ff[9]);
endmodule : mac_cfg_monitor

bind mac_cfg_core mac_cfg_monitor #(.MAX_ATTEMPTS(MAX_ATTEMPTS)) mac_cfg_monitor_i (
	.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .mii_tx_en(mii_tx_en), .link_state_report(link_state_report),
	.fast_speed_select(fast_speed_select), .tx_rewind(tx_rewind), .tx_done(tx_done), .tx_status(tx_status),
	.rx_valid(rx_valid), .rx_end(rx_end), .rx_status(rx_status));

// file: tb/test_ethernet_mac_config_bits.sv
// self-checking bench for the mac configuration block
`timescale 1ns/1ps
module test_ethernet_mac_config_bits;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic        sys_clk, rst, avs_waitrequest, mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_col, mii_tx_en;
	logic        avs_read = 1'b0, avs_write = 1'b0, tx_go = 1'b0, got_end = 1'b0, col_req = 1'b0;
	logic        gmii_mode = 1'b0;
	logic        link_state_report, fast_speed_select, tx_ready, tx_rewind, tx_done, rx_valid, rx_end;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rx_status, rx_stat_got, rd;
	logic [3:0]  avs_byteenable = 4'hf, mii_txd, mii_rxd;
	logic [6:0]  tx_status, tst;
	logic [15:0] lenf;
	logic [7:0]  rx_data, fr [0:20];
	logic [7:0]  rxq [$];
	int          ti = 0, rwn = 0, mismatches = 0, checks = 0;
	wire  [7:0]  tx_data  = fr[ti];
	wire         tx_valid = tx_go && (ti < 20);
	wire         tx_last  = (ti == 19);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	mac_cfg_core #(.MAX_ATTEMPTS(3)) mac_cfg_core_i (
		.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mii_tx_clk(mii_tx_clk), .mii_rx_clk(mii_rx_clk),
		.mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd), .mii_col(mii_col), .gmii_mode(gmii_mode),
		.mii_tx_en(mii_tx_en), .mii_txd(mii_txd), .link_state_report(link_state_report),
		.fast_speed_select(fast_speed_select), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
		.tx_ready(tx_ready), .tx_rewind(tx_rewind), .tx_done(tx_done), .tx_status(tx_status),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .rx_status(rx_status));
	phy_model phy_model_i (.tx_clk(mii_tx_clk), .rx_clk(mii_rx_clk), .rx_dv(mii_rx_dv), .rxd(mii_rxd),
		.col(mii_col), .tx_en(mii_tx_en), .txd(mii_txd), .col_req(col_req));

	// app side: restart from the first byte on rewind, collect delivered bytes
	always @(posedge sys_clk) begin
		if (rx_valid === 1'b1) rxq.push_back(rx_data);
		if (rx_end === 1'b1) got_end <= 1'b1;
		if (rx_end === 1'b1) rx_stat_got <= rx_status;
		if (tx_rewind === 1'b1) ti <= 0;
		else if (tx_ready === 1'b1) ti <= ti + 1;
		if (tx_rewind === 1'b1) rwn <= rwn + 1;
		if (tx_done === 1'b1) tx_go <= 1'b0;
		if (tx_done === 1'b1) tst <= tx_status;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			mismatches++;
			$display("wait expired at %0t", $time);
			wrap_up();
		end
	endtask : tmo
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge sys_clk);
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_write      <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		tmo(n, 50);
		avs_write <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_read    <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		tmo(n, 50);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask : bus_rd
	task automatic send();
		int n;
		@(posedge sys_clk);
		ti      <= 0;
		rwn     <= 0;
		got_end <= 1'b0;
		tx_go   <= 1'b1;
		rxq.delete();
		for (n = 0; n < 20000; n++) begin
			@(posedge sys_clk);
			if (tx_go !== 1'b1) break;
		end
		tmo(n, 20000);
	endtask : send

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		int i;
		int j;
		rst = 1'b1;
		for (i = 0; i < 21; i++) fr[i] = 8'(i);
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		bus_rd(mac_cfg_pkg::CONF_OFS, rd);
		chk(rd, mac_cfg_pkg::CONF_RESET);
		bus_rd(8'h10, rd);
		chk(rd, 32'h0);
		bus_wr(mac_cfg_pkg::CONF_OFS, 32'hffff_ffff, 4'hf);
		bus_rd(mac_cfg_pkg::CONF_OFS, rd);
		chk(rd, 32'h0000_7fe0);
		chk(32'({fast_speed_select, link_state_report}), 32'h3);
		bus_wr(8'h10, 32'h0, 4'hf);
		bus_wr(mac_cfg_pkg::CONF_OFS, 32'h0, 4'h1);
		bus_rd(mac_cfg_pkg::CONF_OFS, rd);
		chk(rd, 32'h0000_7f00);
		// loopback: strip short, keep long, checksum on; then half duplex own echo
		for (i = 0; i < 4; i++) begin
			lenf = (i == 1) ? 16'h05dd : 16'h0002;
			fr[12] = lenf[15:8];
			fr[13] = lenf[7:0];
			bus_wr(mac_cfg_pkg::CONF_OFS,
				(i < 2) ? 32'h0000_1880 : ((i == 2) ? 32'h0000_1c00 : 32'h0000_4000), 4'hf);
			send();
			for (j = 0; j < 20000 && got_end !== 1'b1; j++) @(posedge sys_clk);
			tmo(j, 20000);
			chk(32'(rxq.size()), (i == 0) ? 32'h10 : 32'h14);
			for (j = 0; j < rxq.size(); j++) chk(32'(rxq[j]), 32'(fr[j]));
			chk(32'(rx_stat_got[19:0]), (i == 0) ? 32'h80000 : ((i == 2) ? 32'h0ffff : 32'h0));
		end
		// own echo in half duplex with receive-own disabled: nothing delivered
		bus_wr(mac_cfg_pkg::CONF_OFS, 32'h0000_6000, 4'hf);
		send();
		repeat (60) @(posedge sys_clk);
		chk(32'(rxq.size()) + 32'(got_end), 32'h0);
		// half duplex collisions: single attempt, then retries with the shortest limit
		col_req <= 1'b1;
		for (i = 0; i < 2; i++) begin
			bus_wr(mac_cfg_pkg::CONF_OFS, (i == 0) ? 32'h0000_6200 : 32'h0000_6060, 4'hf);
			send();
			chk(32'(tst), (i == 0) ? 32'h07 : 32'h0f);
			chk(32'(rwn), (i == 0) ? 32'h1 : 32'h3);
		end
		bus_rd(mac_cfg_pkg::STAT_OFS, rd);
		chk(rd, 32'h0000_0f00);
		wrap_up();
	end
endmodule : test_ethernet_mac_config_bits
